// ==== hdlc_tx_fifo_status_test.sv ====
// hdlc_tx_fifo_status_test: self-checking bench for htx_fifo_front
// assumes: checker bound by its own file, packet processor model beside dut
`timescale 1ns/1ps
`default_nettype none
module hdlc_tx_fifo_status_test
    import htx_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic port_status_irq_en = 1'b0;
    logic tx_bit_req;
    htx_bit_s tx_bit;
    logic fifo_ram_power_down;
    logic irq;
    logic pp_run = 1'b0;
    logic pp_slow = 1'b0;
    logic msb = 1'b0;
    logic [7:0] seed = 8'h46;
    int error_cnt = 0;
    int n_tests = 0;
    int i;
    logic [31:0] rd_q[$];
    string nm_q[$];
    htx_bit_s bit_q[$];

    always #5 sys_clk = ~sys_clk;

    htx_fifo_front dut (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_status_irq_en(port_status_irq_en),
        .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .fifo_ram_power_down(fifo_ram_power_down), .irq(irq));
    htx_pp_model u_pp (.sys_clk(sys_clk), .reset(reset), .run(pp_run), .slow(pp_slow), .tx_bit_req(tx_bit_req));

    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // entered just after a rising edge; holds the request until waitrequest is low
    task automatic bus(input logic rd, input logic [9:0] a, input logic [15:0] d, input logic [3:0] be);
        bit done;
        int n;
        done = 1'b0;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        avs_read <= rd;
        avs_write <= !rd;
        for (n = 0; n < 20 && !done; n++) begin
            @(negedge sys_clk);
            done = (avs_waitrequest === 1'b0);
            @(posedge sys_clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
        if (!done) begin
            error_cnt++;
            complete_run();
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string nm);
        rd_q.push_back(exp);
        nm_q.push_back(nm);
        bus(1'b1, a, 16'h0000, 4'h3);
    endtask

    task automatic send(input logic last, input logic note);
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        bus(1'b0, DATA_ADDR, {seed, 7'h00, last}, 4'h3);
        for (int k = 0; k < 8; k++) begin
            if (note) bit_q.push_back({1'b1, (msb ? seed[7-k] : seed[k]), (last && k == 7)});
        end
    endtask

    // requests run on past the last byte so an empty fifo is also asked
    task automatic drain();
        int n;
        for (n = 0; n < 500 && bit_q.size() != 0; n++) @(posedge sys_clk);
        if (bit_q.size() != 0) begin
            error_cnt++;
            complete_run();
        end
        repeat (12) @(posedge sys_clk);
        pp_run <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic irq_is(input logic exp);
        repeat (3) @(negedge sys_clk);
        check("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////
    always @(negedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (rd_q.size() == 0) check("read count", 32'h1, 32'h0);
            else check(nm_q.pop_front(), avs_readdata, rd_q.pop_front());
        end
        if (tx_bit.valid === 1'b1) begin
            if (bit_q.size() == 0) check("extra bit", 32'h1, 32'h0);
            else check("tx bit", {29'h0, tx_bit}, {29'h0, bit_q.pop_front()});
        end
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(CTRL_ADDR, 32'h0800, "control");
        rd(IRQEN_ADDR, 32'h0, "irq enable");
        rd(LATCH_ADDR, 32'h0, "latch");
        bus(1'b0, DATA_ADDR, 16'hA501, 4'h1);
        rd(DATA_ADDR, 32'h0, "data port");
        rd(STATUS_ADDR, 32'h2003, "status");
        rd(10'h3FC, 32'h0, "unmapped");
        for (i = 0; i < 3; i++) send(i == 2, 1'b1);
        rd(STATUS_ADDR, 32'h1F01, "status");
        pp_run <= 1'b1;
        drain();
        rd(LATCH_ADDR, 32'h000A, "latch");
        bus(1'b0, LATCH_ADDR, 16'h0000, 4'h3);
        rd(LATCH_ADDR, 32'h000A, "latch");
        bus(1'b0, CTRL_ADDR, 16'h0808, 4'h3);
        msb = 1'b1;
        send(1'b0, 1'b1);
        send(1'b1, 1'b1);
        pp_slow <= 1'b1;
        pp_run <= 1'b1;
        drain();
        bus(1'b0, LATCH_ADDR, 16'h003F, 4'h3);
        bus(1'b0, CTRL_ADDR, 16'h0800, 4'h3);
        msb = 1'b0;
        send(1'b0, 1'b1);
        pp_slow <= 1'b0;
        pp_run <= 1'b1;
        drain();
        rd(LATCH_ADDR, 32'h0012, "latch");
        bus(1'b0, LATCH_ADDR, 16'h003F, 4'h3);
        bus(1'b0, CTRL_ADDR, 16'h0100, 4'h3);
        for (i = 0; i < 247; i++) send(1'b0, 1'b0);
        rd(STATUS_ADDR, 32'h0101, "status");
        send(1'b0, 1'b0);
        rd(STATUS_ADDR, 32'h0100, "status");
        for (i = 0; i < 7; i++) send(1'b0, 1'b0);
        rd(STATUS_ADDR, 32'h0000, "status");
        send(1'b0, 1'b0);
        rd(STATUS_ADDR, 32'h0004, "status");
        send(1'b0, 1'b0);
        rd(LATCH_ADDR, 32'h0024, "latch");
        bus(1'b0, IRQEN_ADDR, 16'h0024, 4'h3);
        irq_is(1'b0);
        port_status_irq_en <= 1'b1;
        irq_is(1'b1);
        bus(1'b0, LATCH_ADDR, 16'h0020, 4'h3);
        irq_is(1'b1);
        bus(1'b0, LATCH_ADDR, 16'h0004, 4'h3);
        irq_is(1'b0);
        bus(1'b0, CTRL_ADDR, 16'h0801, 4'h3);
        send(1'b1, 1'b0);
        bus(1'b0, LATCH_ADDR, 16'h003F, 4'h3);
        rd(LATCH_ADDR, 32'h0, "latch");
        rd(STATUS_ADDR, 32'h2003, "status");
        bus(1'b0, CTRL_ADDR, 16'h0800, 4'h3);
        rd(LATCH_ADDR, 32'h0003, "latch");
        rd(STATUS_ADDR, 32'h2003, "status");
        bus(1'b0, IRQEN_ADDR, 16'h0003, 4'h3);
        irq_is(1'b1);
        port_status_irq_en <= 1'b0;
        irq_is(1'b0);
        repeat (4) @(posedge sys_clk);
        complete_run();
    end
endmodule
`default_nettype wire

// ==== htx_fifo_front.sv ====
// htx_fifo_front: transmit fifo, status, event latches and interrupt of one port
// assumes: avalon-mm master and packet processor on sys_clk; global enable from
// a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module htx_fifo_front
    import htx_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic port_status_irq_en,
    input wire logic tx_bit_req,
    output htx_bit_s tx_bit,
    output logic fifo_ram_power_down,
    output logic irq
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

    htx_entry_s mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] free_bytes;
    logic [CNT_W-1:0] thr_bytes;
    logic [15:0] ctrl;
    logic [5:0] events;
    logic [5:0] irq_en;
    logic [5:0] ev_set;
    logic [5:0] ev_clr;
    logic staged_last;
    logic ack;
    logic wr_go;
    logic rd_go;
    logic data_upper_wr;
    logic push_req;
    logic push;
    logic pop;
    logic overflow;
    logic underflow;
    logic packet_done;
    logic tx_full;
    logic tx_empty;
    logic tx_space_ok;
    logic [5:0] tx_free_groups;
    logic tx_fifo_clear;
    logic tx_msb_first;
    logic [4:0] tx_space_threshold;
    logic full_q;
    logic empty_q;
    logic space_q;
    logic clear_q;
    logic clear_release;
    logic [15:0] status_word;
    logic [15:0] next_readdata;
    htx_entry_s push_entry;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state on every access, then the access completes
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_go = avs_write && ack;
    assign rd_go = avs_read && !ack;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    always_comb begin
        next_readdata = 16'h0000;
        unique case (avs_address)
            CTRL_ADDR: next_readdata = ctrl;
            DATA_ADDR: next_readdata = 16'h0000;
            STATUS_ADDR: next_readdata = status_word;
            LATCH_ADDR: next_readdata = {10'h000, events};
            IRQEN_ADDR: next_readdata = {10'h000, irq_en};
            default: next_readdata = 16'h0000;
        endcase
    end

    // data is captured in the waiting cycle and stands at the completing edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= {16'h0000, next_readdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and enable registers, written per byte lane
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
        end else if (wr_go && avs_address == CTRL_ADDR) begin
            if (avs_byteenable[0]) begin
                ctrl[7:0] <= avs_writedata[7:0] & CTRL_MASK[7:0];
            end
            if (avs_byteenable[1]) begin
                ctrl[15:8] <= avs_writedata[15:8] & CTRL_MASK[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_en <= IRQEN_RESET;
        end else if (wr_go && avs_address == IRQEN_ADDR && avs_byteenable[0]) begin
            irq_en <= avs_writedata[5:0];
        end
    end

    assign tx_fifo_clear = ctrl[CTRL_CLEAR_BIT];
    assign tx_msb_first = ctrl[CTRL_MSB_FIRST_BIT];
    assign tx_space_threshold = ctrl[CTRL_THR_MSB:CTRL_THR_LSB];
    assign fifo_ram_power_down = tx_fifo_clear;

    ////////////////////////////////////////////////////////////////////////
    // data port: a lone low-byte write stages the end mark for the next
    // high-byte write, so byte-wide software still pairs mark and data
    assign data_upper_wr = wr_go && avs_address == DATA_ADDR && avs_byteenable[1];
    assign push_req = data_upper_wr && !tx_fifo_clear;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            staged_last <= 1'b0;
        end else if (wr_go && avs_address == DATA_ADDR) begin
            if (avs_byteenable[1]) begin
                staged_last <= 1'b0;
            end else if (avs_byteenable[0]) begin
                staged_last <= avs_writedata[DATA_LAST_BIT];
            end
        end
    end

    always_comb begin
        push_entry.data = avs_writedata[DATA_BYTE_MSB:DATA_BYTE_LSB];
        push_entry.last = avs_byteenable[0] ? avs_writedata[DATA_LAST_BIT] : staged_last;
    end

    assign push = push_req && !tx_full;
    assign overflow = push_req && tx_full;

    ////////////////////////////////////////////////////////////////////////
    // fifo storage and pointers
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= push_entry;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (tx_fifo_clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PTR_W'(1);
            end
            if (push && !pop) begin
                count <= count + CNT_W'(1);
            end else if (pop && !push) begin
                count <= count - CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status
    assign free_bytes = DEPTH_C - count;
    assign thr_bytes = CNT_W'({tx_space_threshold, 3'h0}) + CNT_W'(1);
    assign tx_free_groups = 6'(free_bytes >> 3);
    assign tx_full = (count == DEPTH_C);
    assign tx_empty = (count == '0);
    assign tx_space_ok = (free_bytes >= thr_bytes);

    always_comb begin
        status_word = 16'h0000;
        status_word[ST_GROUPS_MSB:ST_GROUPS_LSB] = tx_free_groups;
        status_word[ST_FULL_BIT] = tx_full;
        status_word[ST_EMPTY_BIT] = tx_empty;
        status_word[ST_SPACE_BIT] = tx_space_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // serialiser toward the packet processor
    htx_serializer u_ser (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(tx_fifo_clear),
        .msb_first(tx_msb_first),
        .bit_req(tx_bit_req),
        .head_valid(!tx_empty),
        .head(mem[rd_ptr]),
        .pop(pop),
        .underflow(underflow),
        .packet_done(packet_done),
        .bit_out(tx_bit)
    );

    ////////////////////////////////////////////////////////////////////////
    // edge history; reset values match the status of an empty fifo
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            full_q <= 1'b0;
            empty_q <= 1'b1;
            space_q <= 1'b1;
            clear_q <= 1'b0;
        end else begin
            full_q <= tx_full;
            empty_q <= tx_empty;
            space_q <= tx_space_ok;
            clear_q <= tx_fifo_clear;
        end
    end

    assign clear_release = clear_q && !tx_fifo_clear;

    always_comb begin
        ev_set = 6'h00;
        ev_set[EV_OVER_BIT] = overflow;
        ev_set[EV_UNDER_BIT] = underflow;
        ev_set[EV_PKT_DONE_BIT] = packet_done;
        ev_set[EV_FULL_BIT] = tx_full && !full_q;
        ev_set[EV_EMPTY_BIT] = (tx_empty && !empty_q) || clear_release;
        ev_set[EV_SPACE_BIT] = (tx_space_ok && !space_q) || clear_release;
        ev_clr = 6'h00;
        if (wr_go && avs_address == LATCH_ADDR && avs_byteenable[0]) begin
            ev_clr = avs_writedata[5:0];
        end
    end

    // a new event beats a clear landing in the same cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            events <= EV_RESET;
        end else begin
            events <= (events & ~ev_clr) | ev_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit 2 enable pairs with the full latch like the others
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= port_status_irq_en && |(events & irq_en);
        end
    end

endmodule
`default_nettype wire

// ==== htx_fifo_front_chk.sv ====
// htx_fifo_front_chk: port assertions for the transmit fifo front end
// assumes: bound to htx_fifo_front, single sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module htx_fifo_front_chk
    import htx_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic port_status_irq_en,
    input wire logic tx_bit_req,
    input wire htx_bit_s tx_bit,
    input wire logic fifo_ram_power_down,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [2:0] bit_cnt;
    logic rd_done;
    logic st_rd;
    logic [5:0] groups;
    assign rd_done = avs_read && !avs_waitrequest;
    assign st_rd = rd_done && avs_address == STATUS_ADDR;
    assign groups = avs_readdata[ST_GROUPS_MSB:ST_GROUPS_LSB];
    // bit position in the byte; a clear restarts it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bit_cnt <= 3'h0;
        end else if (fifo_ram_power_down) begin
            bit_cnt <= 3'h0;
        end else if (tx_bit.valid) begin
            bit_cnt <= bit_cnt + 3'h1;
        end
    end
    chk_data_zero: assert property (rd_done && avs_address == DATA_ADDR |-> avs_readdata == 32'h0)
        else $error("data port read not zero");
    chk_bit_on_req: assert property (tx_bit.valid |-> $past(tx_bit_req))
        else $error("bit without request");
    chk_end_eighth: assert property (tx_bit.pkt_end |-> tx_bit.valid && bit_cnt == 3'h7)
        else $error("packet end not on eighth bit");
    chk_empty_groups: assert property (st_rd && avs_readdata[ST_EMPTY_BIT] |-> groups == DEPTH / 8)
        else $error("empty fifo but groups not all free");
    chk_full_status: assert property (st_rd && avs_readdata[ST_FULL_BIT]
        |-> groups == 6'h0 && !avs_readdata[ST_SPACE_BIT] && !avs_readdata[ST_EMPTY_BIT])
        else $error("full status inconsistent");
    chk_empty_only: assert property (st_rd && groups != DEPTH / 8 |-> !avs_readdata[ST_EMPTY_BIT])
        else $error("empty set with data stored");
    chk_clear_halts: assert property (fifo_ram_power_down |=> !tx_bit.valid)
        else $error("bit sent during clear");
    chk_clear_follows: assert property (avs_write && !avs_waitrequest && avs_address == CTRL_ADDR
        && avs_byteenable[0] |=> fifo_ram_power_down == $past(avs_writedata[CTRL_CLEAR_BIT]))
        else $error("power down not following clear bit");
    chk_irq_gated: assert property (irq |-> $past(port_status_irq_en))
        else $error("irq without port enable");
endmodule
bind htx_fifo_front htx_fifo_front_chk #(.DEPTH(DEPTH)) u_chk (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_status_irq_en(port_status_irq_en), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit),
    .fifo_ram_power_down(fifo_ram_power_down), .irq(irq));
`default_nettype wire

// ==== htx_pkg.sv ====
// htx_pkg: constants and types for the hdlc transmit fifo front end
// assumes: 16-bit registers, each on one aligned word of an avalon-mm slave
package htx_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'hA0;
    localparam logic [7:0] DATA_IDX = 8'hA2;
    localparam logic [7:0] STATUS_IDX = 8'hA4;
    localparam logic [7:0] LATCH_IDX = 8'hA6;
    localparam logic [7:0] IRQEN_IDX = 8'hA8;
    localparam int ADDR_W = 10;
    localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
    localparam logic [9:0] DATA_ADDR = {DATA_IDX, 2'h0};
    localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'h0};
    localparam logic [9:0] LATCH_ADDR = {LATCH_IDX, 2'h0};
    localparam logic [9:0] IRQEN_ADDR = {IRQEN_IDX, 2'h0};

    // control field positions
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CTRL_MSB_FIRST_BIT = 3;
    localparam int CTRL_THR_LSB = 8;
    localparam int CTRL_THR_MSB = 12;
    localparam logic [15:0] CTRL_RESET = 16'h0800;
    localparam logic [15:0] CTRL_MASK = 16'h1F7F;

    // data port fields
    localparam int DATA_LAST_BIT = 0;
    localparam int DATA_BYTE_LSB = 8;
    localparam int DATA_BYTE_MSB = 15;

    // status field positions
    localparam int ST_SPACE_BIT = 0;
    localparam int ST_EMPTY_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_GROUPS_LSB = 8;
    localparam int ST_GROUPS_MSB = 13;

    // latched event and enable positions
    localparam int EV_SPACE_BIT = 0;
    localparam int EV_EMPTY_BIT = 1;
    localparam int EV_FULL_BIT = 2;
    localparam int EV_PKT_DONE_BIT = 3;
    localparam int EV_UNDER_BIT = 4;
    localparam int EV_OVER_BIT = 5;
    localparam logic [5:0] EV_RESET = 6'h00;
    localparam logic [5:0] IRQEN_RESET = 6'h00;

    localparam int FIFO_DEPTH = 256;
    localparam logic [2:0] BYTE_LOAD_BITS = 3'h7;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } htx_entry_s;

    typedef struct packed {
        logic valid;
        logic data;
        logic pkt_end;
    } htx_bit_s;

    typedef enum logic [1:0] {
        HTX_IDLE = 2'h0,
        HTX_IN_PKT = 2'h1
    } htx_ser_e;

endpackage

// ==== htx_pp_model.sv ====
// htx_pp_model: packet processor stand-in that asks for bits
// assumes: same sys_clk; run and slow set by the bench
`timescale 1ns/1ps
`default_nettype none
module htx_pp_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic slow,
    output logic tx_bit_req
);
    logic phase;
    // keeps asking even when the fifo runs dry, as a real line would
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase <= 1'b0;
            tx_bit_req <= 1'b0;
        end else begin
            phase <= ~phase;
            tx_bit_req <= run && (!slow || phase);
        end
    end
endmodule
`default_nettype wire

// ==== htx_serializer.sv ====
// htx_serializer: turns fifo bytes into single bits on request
// assumes: the packet processor asks for one bit per cycle at most, same clock
`timescale 1ns/1ps
`default_nettype none
module htx_serializer
    import htx_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic msb_first,
    input wire logic bit_req,
    input wire logic head_valid,
    input wire htx_entry_s head,
    output logic pop,
    output logic underflow,
    output logic packet_done,
    output htx_bit_s bit_out
);

    logic [7:0] shift;
    logic [2:0] bits_left;
    logic last_flag;
    logic msb_q;
    logic need;
    htx_ser_e state;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        need = bit_req && (bits_left == 3'h0) && !clear;
        pop = need && head_valid;
        underflow = need && !head_valid && (state == HTX_IN_PKT);
        packet_done = pop && head.last;
    end

    ////////////////////////////////////////////////////////////////////////
    // bit order is frozen per byte so a mid-byte change cannot split it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shift <= 8'h00;
            bits_left <= 3'h0;
            last_flag <= 1'b0;
            msb_q <= 1'b0;
            bit_out <= '0;
        end else if (clear) begin
            bits_left <= 3'h0;
            last_flag <= 1'b0;
            bit_out <= '0;
        end else if (pop) begin
            msb_q <= msb_first;
            last_flag <= head.last;
            bits_left <= BYTE_LOAD_BITS;
            bit_out.valid <= 1'b1;
            bit_out.pkt_end <= 1'b0;
            if (msb_first) begin
                bit_out.data <= head.data[7];
                shift <= {head.data[6:0], 1'b0};
            end else begin
                bit_out.data <= head.data[0];
                shift <= {1'b0, head.data[7:1]};
            end
        end else if (bit_req && bits_left != 3'h0) begin
            bits_left <= bits_left - 3'h1;
            bit_out.valid <= 1'b1;
            bit_out.pkt_end <= last_flag && (bits_left == 3'h1);
            if (msb_q) begin
                bit_out.data <= shift[7];
                shift <= {shift[6:0], 1'b0};
            end else begin
                bit_out.data <= shift[0];
                shift <= {1'b0, shift[7:1]};
            end
        end else begin
            bit_out <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= HTX_IDLE;
        end else begin
            unique case (state)
                HTX_IDLE: begin
                    if (pop && !head.last && !clear) begin
                        state <= HTX_IN_PKT;
                    end
                end
                HTX_IN_PKT: begin
                    if (clear || (pop && head.last)) begin
                        state <= HTX_IDLE;
                    end
                end
            endcase
        end
    end

endmodule
`default_nettype wire
